/* File: shared/nci_pkg.sv */
package nci_pkg;

	// ------------------------------------------------------------
	// array geometry
	// ------------------------------------------------------------
	localparam int unsigned PAGE_COUNT = 131072;
	localparam int unsigned PAGE_BYTES = 528;
	localparam int unsigned SPARE_FIRST_COL = 512;
	localparam int unsigned BLOCK_COUNT = 4096;
	localparam int unsigned PLANE_COUNT = 4;
	localparam int unsigned PLANE_BLOCKS = 1024;
	localparam int unsigned ADDR_BITS = 26;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_LO = 8'h00;
	localparam logic [7:0] CMD_READ_HI = 8'h01;
	localparam logic [7:0] CMD_READ_SPARE = 8'h50;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_CONF_TRUE = 8'h10;
	localparam logic [7:0] CMD_CONF_DUMMY = 8'h11;
	localparam logic [7:0] CMD_CB_DUMMY = 8'h03;
	localparam logic [7:0] CMD_CB_PROG = 8'h8a;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_MP_STATUS = 8'h71;

	// ------------------------------------------------------------
	// strobe timing, cycles of the 50 ns core clock
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned STROBE_LOW_NS = 50;
	localparam int unsigned STROBE_HIGH_NS = 50;
	localparam logic [3:0] STROBE_LOW_CYC =
		4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] STROBE_HIGH_CYC =
		4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] BUSY_WAIT_CYC = 4'h4;

	// ------------------------------------------------------------
	// host request kinds
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		NCI_OP_CMD = 3'b000,
		NCI_OP_ADDR = 3'b001,
		NCI_OP_WDATA = 3'b010,
		NCI_OP_RDATA = 3'b011,
		NCI_OP_WAIT = 3'b100
	} nci_op_e;

endpackage

/* File: rtl/nci_sync2.sv */
module nci_sync2
	import nci_pkg::*;
#(
	parameter int unsigned W = 1
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// level in and out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// two-stage synchroniser, first stage only feeds the second
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule

/* File: rtl/nci_buf2.sv */
module nci_buf2
	import nci_pkg::*;
#(
	parameter int unsigned W = 8,
	parameter int unsigned DEPTH = 2
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int unsigned PW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [PW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (cnt_reg < (PW+1)'(DEPTH)); // room while not full
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rd_reg];

	// pointer and count update
	always_comb begin
		wr_next = push ? ((wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1) : wr_reg;
		rd_next = pop ? ((rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage, written only on push
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

endmodule

/* File: rtl/nci_host.sv */
module nci_host
	import nci_pkg::*;
#(
	parameter bit LOW_VOLTAGE = 1'b0
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// request port
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [2:0] req_op,
	input wire logic [7:0] req_byte,
	input wire logic req_last,
	output logic req_error,
	// read data port
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	// flash pins
	output logic chip_sel_n,
	output logic cmd_latch,
	output logic addr_latch,
	output logic write_strobe_n,
	output logic output_strobe_n,
	output logic write_prot_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe_n,
	input wire logic ready_busy,
	// status
	output logic flash_busy
);

	// ------------------------------------------------------------
	// state and declarations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		NCI_IDLE = 3'b000,
		NCI_WLOW = 3'b001,
		NCI_WHIGH = 3'b010,
		NCI_RLOW = 3'b011,
		NCI_RHIGH = 3'b100,
		NCI_BWAIT = 3'b101
	} nci_state_e;

	nci_state_e state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [2:0] op_reg, op_next;
	logic [7:0] byte_reg, byte_next;
	logic last_reg, last_next;
	logic [2:0] acnt_reg, acnt_next;
	logic [2:0] aneed_reg, aneed_next;
	logic hi_half_reg, hi_half_next;
	logic err_reg, err_next;
	logic [7:0] io_sync;
	logic rb_sync;
	logic buf_in_ready;
	logic buf_in_valid;
	logic [7:0] buf_in_data;
	logic take;

	// pin inputs through two flip-flops
	nci_sync2 #(.W(9)) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.async_in({ready_busy, io_in}),
		.sync_out({rb_sync, io_sync})
	);

	// read bytes pass a two-entry buffer so a stall loses nothing
	nci_buf2 #(.W(8), .DEPTH(2)) u_buf (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// ------------------------------------------------------------
	// command checks
	// ------------------------------------------------------------
	function automatic logic cmd_defined(input logic [7:0] c, input logic lv);
		logic mp;
		mp = (c == CMD_CONF_DUMMY) || (c == CMD_CB_DUMMY) || (c == CMD_CB_PROG)
			|| (c == CMD_MP_STATUS);
		cmd_defined = (c == CMD_READ_LO) || (c == CMD_READ_HI) || (c == CMD_READ_SPARE)
			|| (c == CMD_READ_ID) || (c == CMD_RESET) || (c == CMD_PROG)
			|| (c == CMD_CONF_TRUE) || (c == CMD_ERASE) || (c == CMD_ERASE_CONF)
			|| (c == CMD_STATUS) || (mp && !lv);
	endfunction

	function automatic logic busy_ok(input logic [7:0] c);
		busy_ok = (c == CMD_RESET) || (c == CMD_STATUS) || (c == CMD_MP_STATUS);
	endfunction

	// a request is refused when it would break the command set or busy rules
	function automatic logic refuse(input logic [2:0] op, input logic [7:0] c,
			input logic busy, input logic lv, input logic [2:0] na, input logic [2:0] ac);
		refuse = 1'b0;
		if (op == NCI_OP_CMD) begin
			refuse = !cmd_defined(c, lv) || (busy && !busy_ok(c));
		end else if (op == NCI_OP_ADDR) begin
			refuse = busy || (ac >= na);
		end else if (op == NCI_OP_WDATA || op == NCI_OP_RDATA) begin
			refuse = busy;
		end
	endfunction

	assign take = req_valid && req_ready;
	assign req_ready = (state_reg == NCI_IDLE) && buf_in_ready;
	assign req_error = err_reg;
	assign flash_busy = !rb_sync;
	assign write_prot_n = 1'b1;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		op_next = op_reg;
		byte_next = byte_reg;
		last_next = last_reg;
		acnt_next = acnt_reg;
		aneed_next = aneed_reg;
		hi_half_next = hi_half_reg;
		err_next = 1'b0;
		buf_in_valid = 1'b0;
		buf_in_data = io_sync;
		unique case (state_reg)
			NCI_IDLE: begin
				if (take) begin
					if (refuse(req_op, req_byte, !rb_sync, LOW_VOLTAGE, aneed_reg,
							acnt_reg)) begin
						err_next = 1'b1;
					end else begin
						op_next = req_op;
						byte_next = req_byte;
						last_next = req_last;
						cnt_next = STROBE_LOW_CYC;
						if (req_op == NCI_OP_WAIT) begin
							state_next = NCI_BWAIT;
							cnt_next = BUSY_WAIT_CYC;
						end else if (req_op == NCI_OP_RDATA) begin
							state_next = NCI_RLOW;
						end else begin
							state_next = NCI_WLOW;
						end
						if (req_op == NCI_OP_CMD) begin
							acnt_next = '0;
							// erase takes three row cycles, read ID one, reads, program and copy-back dummy four, the rest none
							if (req_byte == CMD_ERASE) begin
								aneed_next = 3'd3;
							end else if (req_byte == CMD_READ_ID) begin
								aneed_next = 3'd1;
							end else if (req_byte == CMD_READ_LO || req_byte == CMD_READ_HI
									|| req_byte == CMD_READ_SPARE || req_byte == CMD_PROG
									|| req_byte == CMD_CB_DUMMY) begin
								aneed_next = 3'd4;
							end else begin
								aneed_next = '0;
							end
							if (req_byte == CMD_READ_HI) begin
								hi_half_next = 1'b1;
							end else if (req_byte == CMD_READ_LO || req_byte == CMD_RESET) begin
								hi_half_next = 1'b0;
							end
						end else if (req_op == NCI_OP_ADDR) begin
							acnt_next = acnt_reg + 3'd1;
						end
					end
				end
			end
			NCI_WLOW: begin
				// hold write strobe low for its time
				cnt_next = cnt_reg - 4'd1;
				if (cnt_reg == 4'd1) begin
					state_next = NCI_WHIGH;
					cnt_next = STROBE_HIGH_CYC;
				end
			end
			NCI_RLOW: begin
				cnt_next = cnt_reg - 4'd1;
				if (cnt_reg == 4'd1) begin
					// one extra high cycle covers the two-flop lag on the bus
					state_next = NCI_RHIGH;
					cnt_next = STROBE_HIGH_CYC + 4'd1;
					hi_half_next = 1'b0;
				end
			end
			NCI_WHIGH, NCI_RHIGH: begin
				cnt_next = cnt_reg - 4'd1;
				if (cnt_reg == 4'd1) begin
					// a read byte is taken once it has passed the synchroniser
					buf_in_valid = (state_reg == NCI_RHIGH);
					state_next = NCI_IDLE;
				end
			end
			NCI_BWAIT: begin
				// allow ready/busy time to fall before trusting it
				if (cnt_reg != 4'd0) begin
					cnt_next = cnt_reg - 4'd1;
				end else if (rb_sync) begin
					state_next = NCI_IDLE;
				end
			end
			default: begin
				state_next = NCI_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_reg <= NCI_IDLE;
			cnt_reg <= '0;
			op_reg <= NCI_OP_CMD;
			byte_reg <= '0;
			last_reg <= 1'b1;
			acnt_reg <= '0;
			aneed_reg <= '0;
			hi_half_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			op_reg <= op_next;
			byte_reg <= byte_next;
			last_reg <= last_next;
			acnt_reg <= acnt_next;
			aneed_reg <= aneed_next;
			hi_half_reg <= hi_half_next;
			err_reg <= err_next;
		end
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	logic ce_n_reg, cle_reg, ale_reg, we_n_reg, re_n_reg, oe_n_reg;
	logic [7:0] io_reg;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ce_n_reg <= 1'b1;
			cle_reg <= 1'b0;
			ale_reg <= 1'b0;
			we_n_reg <= 1'b1;
			re_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			io_reg <= '0;
		end else begin
			// strobe low with latch enables marking the byte
			we_n_reg <= !(state_next == NCI_WLOW);
			re_n_reg <= !(state_next == NCI_RLOW);
			cle_reg <= (state_next == NCI_WLOW || state_next == NCI_WHIGH)
				&& op_next == NCI_OP_CMD;
			ale_reg <= (state_next == NCI_WLOW || state_next == NCI_WHIGH)
				&& op_next == NCI_OP_ADDR;
			oe_n_reg <= !(state_next == NCI_WLOW || state_next == NCI_WHIGH);
			// fourth address cycle forces the upper seven bits low
			io_reg <= (op_next == NCI_OP_ADDR && acnt_next == 3'd4)
				? {7'h00, byte_next[0]} : byte_next;
			// select held low through a busy wait
			ce_n_reg <= (state_next == NCI_IDLE) && last_next && !(op_next == NCI_OP_WAIT);
		end
	end

	assign chip_sel_n = ce_n_reg;
	assign cmd_latch = cle_reg;
	assign addr_latch = ale_reg;
	assign write_strobe_n = we_n_reg;
	assign output_strobe_n = re_n_reg;
	assign io_out = io_reg;
	assign io_oe_n = oe_n_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_wlow;
		!write_strobe_n;
	endsequence

	strobe_excl_a: assert property (@(posedge core_clk) disable iff (reset)
		!(!write_strobe_n && !output_strobe_n)) else $error("both strobes low");
	write_sel_a: assert property (@(posedge core_clk) disable iff (reset)
		s_wlow |-> !chip_sel_n && !io_oe_n) else $error("write without select");
	latch_excl_a: assert property (@(posedge core_clk) disable iff (reset)
		!(cmd_latch && addr_latch)) else $error("both latches high");
	addr_four_a: assert property (@(posedge core_clk) disable iff (reset)
		(addr_latch && acnt_reg == 3'd4) |-> io_out[7:1] == 7'h00)
		else $error("fourth address upper bits set");
	busy_cmd_a: assert property (@(posedge core_clk) disable iff (reset)
		(take && req_op == NCI_OP_CMD && !rb_sync && !busy_ok(req_byte))
		|=> err_reg && state_reg == NCI_IDLE) else $error("command issued while busy");
	undef_cmd_a: assert property (@(posedge core_clk) disable iff (reset)
		$rose(cmd_latch) |-> cmd_defined(io_out, LOW_VOLTAGE))
		else $error("undefined command driven");
	erase_addr_a: assert property (@(posedge core_clk) disable iff (reset)
		$rose(addr_latch) |-> acnt_reg <= aneed_reg) else $error("extra address cycle");
	read_done_a: assert property (@(posedge core_clk) disable iff (reset)
		$fell(output_strobe_n) |-> ##[1:2] $rose(output_strobe_n))
		else $error("read strobe stuck low");
	half_rev_a: assert property (@(posedge core_clk) disable iff (reset)
		$rose(output_strobe_n) |-> !hi_half_reg) else $error("half pointer not reverted");

endmodule

/* File: test/nci_flash_model.sv */
module nci_flash_model #(
	parameter int BUSY_CYC = 20
)(
	// clock
	input wire logic core_clk,
	// flash pins
	input wire logic chip_sel_n,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic [7:0] io_bus,
	output logic [7:0] io_drive,
	output logic rb_low,
	// observation
	output logic [7:0] last_cmd,
	output logic [3:0] addr_cnt,
	output logic [7:0] addr_byte [0:3]
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// page register and pointers
	// ------------------------------------------------------------
	logic [7:0] pb [0:527];
	logic [7:0] drv;
	logic hi_half;
	int col;
	realtime busy_until;
	initial begin
		for (int i = 0; i < 528; i++) pb[i] = 8'(i >> 1) ^ {7'h0, i[0]};
		drv = 8'h00;
		hi_half = 1'b0;
		col = 0;
		busy_until = 0;
		last_cmd = 8'h00;
		addr_cnt = 4'h0;
	end
	// bytes taken on write strobe rise, read bytes on output strobe fall
	always @(posedge write_strobe_n or negedge output_strobe_n) begin
		if (chip_sel_n) begin
		end else if (!output_strobe_n) begin
			drv <= pb[col % 528];
			col <= col + 1;
		end else if (cmd_latch) begin
			if ($realtime >= busy_until || io_bus inside {8'hff, 8'h70, 8'h71}) begin
				last_cmd <= io_bus;
				addr_cnt <= 4'h0;
				hi_half <= (io_bus == 8'h01);
				if (io_bus == 8'hff) busy_until = 0;
				if (io_bus inside {8'h10, 8'hd0}) busy_until = $realtime + BUSY_CYC * 50;
			end
		end else if (addr_latch) begin
			if (addr_cnt < 4) begin
				addr_byte[addr_cnt[1:0]] <= io_bus;
				addr_cnt <= addr_cnt + 4'h1;
				if (addr_cnt == 0) col <= {hi_half, io_bus};
				if (addr_cnt == 3 && last_cmd inside {8'h00, 8'h01})
					busy_until = $realtime + BUSY_CYC * 50;
			end
		end else begin
			pb[col % 528] <= io_bus;
			col <= col + 1;
		end
	end
	// open-drain busy pull-down
	always @(posedge core_clk) rb_low <= ($realtime < busy_until);
	// deselected bus shows the inverse of the last byte
	assign io_drive = chip_sel_n ? ~drv : drv;
endmodule

/* File: test/nci_host_tb.sv */
module nci_host_tb;
	import nci_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	logic req_ready;
	logic [2:0] req_op = 3'h0;
	logic [7:0] req_byte = 8'h00;
	logic req_last = 1'b0;
	logic req_error;
	logic rd_valid;
	logic rd_ready = 1'b0;
	logic [7:0] rd_data;
	logic chip_sel_n, cmd_latch, addr_latch, write_strobe_n, output_strobe_n, write_prot_n;
	logic [7:0] io_in, io_out, io_drive;
	logic io_oe_n, ready_busy, rb_low, flash_busy;
	logic [7:0] last_cmd;
	logic [3:0] addr_cnt;
	logic [7:0] addr_byte [0:3];
	int error_cnt = 0;
	int n_compared = 0;
	logic lv_req_error;
	int lv_refusals = 0;
	// clock and bus resolution
	always #25 core_clk = ~core_clk;
	assign io_in = io_oe_n ? io_drive : io_out;
	assign ready_busy = rb_low ? 1'b0 : 1'b1; // pull-up on ready/busy
	nci_host #(.LOW_VOLTAGE(1'b0)) DUT (.core_clk(core_clk), .reset(reset),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_byte(req_byte), .req_last(req_last), .req_error(req_error),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
		.write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
		.write_prot_n(write_prot_n), .io_in(io_in), .io_out(io_out),
		.io_oe_n(io_oe_n), .ready_busy(ready_busy), .flash_busy(flash_busy));
	nci_flash_model #(.BUSY_CYC(20)) flash (.core_clk(core_clk),
		.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
		.write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
		.io_bus(io_in), .io_drive(io_drive), .rb_low(rb_low),
		.last_cmd(last_cmd), .addr_cnt(addr_cnt), .addr_byte(addr_byte));
	// low-voltage build shadows the same requests and must refuse multi-plane codes
	nci_host #(.LOW_VOLTAGE(1'b1)) DUT_LV (.core_clk(core_clk), .reset(reset),
		.req_valid(req_valid), .req_ready(), .req_op(req_op),
		.req_byte(req_byte), .req_last(req_last), .req_error(lv_req_error),
		.rd_valid(), .rd_ready(rd_ready), .rd_data(),
		.chip_sel_n(), .cmd_latch(), .addr_latch(),
		.write_strobe_n(), .output_strobe_n(),
		.write_prot_n(), .io_in(io_in), .io_out(),
		.io_oe_n(), .ready_busy(ready_busy), .flash_busy());
	// count refusals of the low-voltage build
	always @(posedge core_clk) begin
		if (lv_req_error === 1'b1) lv_refusals++;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] exp_byte(input int i);
		return 8'(i >> 1) ^ {7'h0, i[0]};
	endfunction
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one request, held until taken, refusal checked one cycle after
	task automatic req(input logic [2:0] op, input logic [7:0] b, input logic last,
			input logic exp_err);
		int n;
		n = 0;
		@(negedge core_clk);
		req_valid = 1'b1;
		req_op = op;
		req_byte = b;
		req_last = last;
		while (req_ready !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 400) chk("req_ready", 16'h0, 16'h1);
		@(posedge core_clk);
		@(negedge core_clk);
		req_valid = 1'b0;
		chk("req_error", {15'h0, req_error}, {15'h0, exp_err});
		repeat (2) @(negedge core_clk); // let the strobes finish before the far side is read
	endtask
	task automatic pop(input logic [7:0] exp);
		@(negedge core_clk);
		rd_ready = 1'b1;
		chk("rd_valid", {15'h0, rd_valid}, 16'h1);
		chk("rd_data", {8'h0, rd_data}, {8'h0, exp});
		@(posedge core_clk);
		@(negedge core_clk);
		rd_ready = 1'b0;
	endtask
	task automatic addr4(input logic [7:0] a0, input logic [7:0] a3);
		req(NCI_OP_ADDR, a0, 1'b0, 1'b0);
		req(NCI_OP_ADDR, 8'h00, 1'b0, 1'b0);
		req(NCI_OP_ADDR, 8'h00, 1'b0, 1'b0);
		req(NCI_OP_ADDR, a3, 1'b0, 1'b0);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_status;
		req(NCI_OP_CMD, CMD_STATUS, 1'b1, 1'b0);
		chk("cmd_seen", {8'h0, last_cmd}, 16'h0070);
		chk("sel_released", {15'h0, chip_sel_n}, 16'h1);
		chk("bus_released", {15'h0, io_oe_n}, 16'h1);
		chk("wp_high", {15'h0, write_prot_n}, 16'h1);
	endtask
	task automatic t_read_halves;
		req(NCI_OP_CMD, CMD_READ_HI, 1'b0, 1'b0);
		addr4(8'h10, 8'h00);
		req(NCI_OP_ADDR, 8'h00, 1'b0, 1'b1);
		req(NCI_OP_WAIT, 8'h00, 1'b0, 1'b0);
		req(NCI_OP_RDATA, 8'h00, 1'b0, 1'b0);
		req(NCI_OP_RDATA, 8'h00, 1'b1, 1'b0);
		repeat (6) @(negedge core_clk);
		chk("buf_full_ready", {15'h0, req_ready}, 16'h0);
		pop(exp_byte(272));
		pop(exp_byte(273));
		req(NCI_OP_CMD, CMD_READ_LO, 1'b0, 1'b0);
		addr4(8'h10, 8'h00);
		req(NCI_OP_WAIT, 8'h00, 1'b0, 1'b0);
		req(NCI_OP_RDATA, 8'h00, 1'b1, 1'b0);
		pop(exp_byte(16));
	endtask
	task automatic t_program;
		req(NCI_OP_CMD, CMD_PROG, 1'b0, 1'b0);
		addr4(8'h05, 8'hff);
		chk("addr_first", {8'h0, addr_byte[0]}, 16'h0005);
		chk("addr_fourth", {8'h0, addr_byte[3]}, 16'h0001);
		req(NCI_OP_WDATA, 8'hab, 1'b0, 1'b0);
		req(NCI_OP_WDATA, 8'hcd, 1'b0, 1'b0);
		req(NCI_OP_CMD, CMD_CONF_TRUE, 1'b1, 1'b0);
		repeat (6) @(negedge core_clk);
		chk("busy", {15'h0, flash_busy}, 16'h1);
		req(NCI_OP_CMD, CMD_PROG, 1'b0, 1'b1);
		req(NCI_OP_ADDR, 8'h00, 1'b0, 1'b1);
		req(NCI_OP_CMD, CMD_STATUS, 1'b1, 1'b0);
		chk("status_busy", {8'h0, last_cmd}, 16'h0070);
		req(NCI_OP_WAIT, 8'h00, 1'b1, 1'b0);
		chk("idle", {15'h0, flash_busy}, 16'h0);
	endtask
	task automatic t_erase;
		req(NCI_OP_CMD, CMD_ERASE, 1'b0, 1'b0);
		req(NCI_OP_ADDR, 8'h20, 1'b0, 1'b0);
		req(NCI_OP_ADDR, 8'h01, 1'b0, 1'b0);
		req(NCI_OP_ADDR, 8'h00, 1'b0, 1'b0);
		req(NCI_OP_ADDR, 8'h00, 1'b0, 1'b1);
		chk("erase_addr_cnt", {12'h0, addr_cnt}, 16'h0003);
		req(NCI_OP_CMD, CMD_ERASE_CONF, 1'b1, 1'b0);
		repeat (6) @(negedge core_clk);
		chk("erase_busy", {15'h0, flash_busy}, 16'h1);
		req(NCI_OP_CMD, CMD_MP_STATUS, 1'b0, 1'b0);
		req(NCI_OP_CMD, CMD_RESET, 1'b1, 1'b0);
		req(NCI_OP_WAIT, 8'h00, 1'b1, 1'b0);
		chk("reset_idle", {15'h0, flash_busy}, 16'h0);
	endtask
	task automatic t_codes;
		int n0;
		req(NCI_OP_CMD, 8'h42, 1'b1, 1'b1);
		req(NCI_OP_CMD, 8'hd5, 1'b1, 1'b1);
		n0 = lv_refusals;
		req(NCI_OP_CMD, CMD_CB_DUMMY, 1'b0, 1'b0);
		chk("lv_refuse", 16'(lv_refusals - n0), 16'h0001);
		req(NCI_OP_CMD, CMD_RESET, 1'b1, 1'b0);
		chk("last_reset", {8'h0, last_cmd}, 16'h00ff);
	endtask
	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#(20000 * 50);
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		repeat (3) @(negedge core_clk); // let the ready/busy sync settle
		t_status();
		t_read_halves();
		t_program();
		t_erase();
		t_codes();
		finish_test();
	end
endmodule
